//--- pkg/cstc_consts.vh
// register offsets, field positions, reset values and fault confinement limits
`ifndef CSTC_CONSTS_VH
`define CSTC_CONSTS_VH
`define CSTC_ADDR_FIFO 4'h0
`define CSTC_ADDR_INTF 4'h1
`define CSTC_ADDR_INTE 4'h2
`define CSTC_ADDR_EC 4'h3
`define CSTC_ADDR_CFG_A 4'h4
`define CSTC_ADDR_CFG_B 4'h5
`define CSTC_ADDR_FEN 4'h6
`define CSTC_ADDR_CTRL 4'h7
`define CSTC_INTF_LOW_MASK 8'hEF
`define CSTC_CFG_A_MASK 16'h00FF
`define CSTC_CFG_B_MASK 16'h47FF
`define CSTC_FEN_RESET 16'hFFFF
`define CSTC_BIT_TX_BUS_OFF 13
`define CSTC_BIT_TXEP 12
`define CSTC_BIT_RXEP 11
`define CSTC_BIT_TXW 10
`define CSTC_BIT_RXW 9
`define CSTC_BIT_EW 8
`define CSTC_WARN_LIMIT 9'h060
`define CSTC_PASSIVE_LIMIT 9'h080
`define CSTC_BUSOFF_LIMIT 9'h100
`define CSTC_FILTER_TAPS 3
`endif

//--- design/cstc_quantum.v
// time quantum prescaler: one tick every 2*(prescaler+1) clocks
`timescale 1ns/1ps
module cstc_quantum #(
    parameter PW = 6
) (
    input wire sys_clk,
    input wire rst,
    input wire [PW-1:0] quantum_prescaler,
    output reg tq_tick
);
    reg [PW:0] count;
    wire [PW:0] last = {quantum_prescaler, 1'b1};
    always @(posedge sys_clk) begin
        if (rst) begin
            count <= {(PW+1){1'b0}};
            tq_tick <= 1'b0;
        end else if (count >= last) begin // see [R15]
            count <= {(PW+1){1'b0}};
            tq_tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tq_tick <= 1'b0;
        end
    end
endmodule // cstc_quantum

//--- design/cstc_top.v
// can status, interrupt flags, error counters and bit timing
//
// Summary of operation
// [R01] fifo_write_index reports next buffer written by reception, 0 to 31
// [R02] fifo_next_read_index sits in low six bits of fifo status
// [R03] tx_bus_off status bit set while transmitter is bus-off
// [R04] separate error-passive bits for transmitter and receiver
// [R05] tx and rx warning bits, combined warning set if either warns
// [R06] error flag set from the error-state status bits
// [R07] invalid message sets flag; low-byte flags clear-only by software
// [R08] bus activity sets the wake flag
// [R09] receive fifo nearing capacity sets almost-full flag
// [R10] message into unemptied receive buffer sets overflow flag
// [R11] message stored sets rx flag; transmit completion sets tx flag
// [R12] enable per low-byte flag; zero keeps flag off the interrupt
// [R13] tx error count in upper byte, rx count in lower byte
// [R14] jump width is field plus one quanta
// [R15] time quantum is 2*(prescaler+1) clock periods
// [R16] wake detect uses line filter when select is one, else raw line
// [R17] phase two is field plus one quanta
// [R18] free phase two when select set, else max of phase one and ipt
// [R19] triple sampling at sample point when select set, else single
// [R20] phase one is field plus one quanta
// [R21] propagation segment is field plus one quanta
// [R22] sixteen filter enables, all one after reset
// [R23] listen-only freezes error counters, no error flags or acks
// [R24] warning, passive, bus-off derived from counters at can thresholds
`timescale 1ns/1ps
`include "cstc_consts.vh"
module cstc_top #(
    parameter IPT_TQ = 2,
    parameter FIFO_AW = 5
) (
    input wire sys_clk,
    input wire rst,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // events from the message engine
    input wire ev_fifo_write,
    input wire ev_fifo_read,
    input wire [4:0] fifo_almost_level,
    input wire ev_invalid_msg,
    input wire ev_rx_stored,
    input wire ev_rx_overflow,
    input wire ev_tx_done,
    input wire ev_tx_error,
    input wire ev_tx_success,
    input wire ev_rx_error,
    input wire ev_rx_success,
    input wire listen_only,
    input wire wake_armed,
    input wire can_rx,
    // outputs
    output reg irq,
    output reg [15:0] acceptance_filter_on,
    output reg sample_point,
    output reg sampled_bit,
    output reg resync_window,
    output reg err_frame_allowed,
    output reg ack_allowed
);
    // ----------------------------------------
    // register storage
    // ----------------------------------------
    reg [7:0] flags_low;
    reg [7:0] inte;
    reg [15:0] cfg_a;
    reg [15:0] cfg_b;
    reg [7:0] tx_fault_count;
    reg [7:0] rx_fault_count;
    reg tx_bus_off;
    reg [FIFO_AW:0] fifo_write_index;
    reg [FIFO_AW:0] fifo_next_read_index;
    reg [4:0] almost_thr;
    reg done;

    wire [1:0] resync_jump_width = cfg_a[7:6];
    wire [5:0] quantum_prescaler = cfg_a[5:0];
    wire wake_line_filter_select = cfg_b[14];
    wire [2:0] phase_two_length = cfg_b[10:8];
    wire phase_two_free_select = cfg_b[7];
    wire triple_sample_select = cfg_b[6];
    wire [2:0] phase_one_length = cfg_b[5:3];
    wire [2:0] propagation_length = cfg_b[2:0];

    // ----------------------------------------
    // fault confinement status
    // ----------------------------------------
    function lim;
        input [7:0] cnt;
        input [8:0] thr;
        lim = ({1'b0, cnt} >= thr);
    endfunction

    wire tx_warning = lim(tx_fault_count, `CSTC_WARN_LIMIT); // see [R24]
    wire rx_warning = lim(rx_fault_count, `CSTC_WARN_LIMIT); // see [R24]
    wire tx_error_passive = lim(tx_fault_count, `CSTC_PASSIVE_LIMIT) & ~tx_bus_off; // see [R04]
    wire rx_error_passive = lim(rx_fault_count, `CSTC_PASSIVE_LIMIT); // see [R04]
    wire any_error_warning = tx_warning | rx_warning; // see [R05]
    wire [7:0] status_high = {2'b00, tx_bus_off, tx_error_passive, rx_error_passive,
        tx_warning, rx_warning, any_error_warning}; // see [R03] see [R05]
    reg [7:0] status_prev;
    wire error_rise = |(status_high & ~status_prev); // see [R06]

    // ----------------------------------------
    // error counters
    // ----------------------------------------
    function [7:0] cnt_add;
        input [7:0] c;
        input [3:0] n;
        // saturate at 255 whatever the step size
        cnt_add = (c > 8'hFF - {4'h0, n}) ? 8'hFF : c + {4'h0, n};
    endfunction

    always @(posedge sys_clk) begin
        if (rst) begin
            tx_fault_count <= 8'h00;
            rx_fault_count <= 8'h00;
            tx_bus_off <= 1'b0;
        end else if (!listen_only) begin // see [R23]
            if (ev_tx_error) begin
                tx_fault_count <= cnt_add(tx_fault_count, 4'h8);
                if ({1'b0, tx_fault_count} + 9'h008 >= `CSTC_BUSOFF_LIMIT)
                    tx_bus_off <= 1'b1; // see [R24]
            end else if (ev_tx_success && tx_fault_count != 8'h00) begin
                tx_fault_count <= tx_fault_count - 8'h01;
            end
            if (ev_rx_error)
                rx_fault_count <= cnt_add(rx_fault_count, 4'h1);
            else if (ev_rx_success && rx_fault_count != 8'h00)
                rx_fault_count <= rx_fault_count - 8'h01;
        end
    end

    // ----------------------------------------
    // fifo pointers
    // ----------------------------------------
    wire [FIFO_AW:0] fill = fifo_write_index - fifo_next_read_index;
    always @(posedge sys_clk) begin
        if (rst) begin
            fifo_write_index <= {(FIFO_AW+1){1'b0}};
            fifo_next_read_index <= {(FIFO_AW+1){1'b0}};
        end else begin
            if (ev_fifo_write)
                fifo_write_index <= {1'b0, fifo_write_index[FIFO_AW-1:0] + 1'b1}; // see [R01]
            if (ev_fifo_read)
                fifo_next_read_index <= {1'b0, fifo_next_read_index[FIFO_AW-1:0] + 1'b1}; // see [R02]
        end
    end

    // ----------------------------------------
    // wake line filter
    // ----------------------------------------
    reg [2:0] rx_sync;
    reg rx_clean;
    reg [`CSTC_FILTER_TAPS-1:0] filt;
    reg rx_filt;
    reg wake_prev;
    always @(posedge sys_clk) begin
        if (rst) begin
            rx_sync <= 3'h7;
            rx_clean <= 1'b1;
            filt <= {`CSTC_FILTER_TAPS{1'b1}};
            rx_filt <= 1'b1;
            wake_prev <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], can_rx};
            if (rx_sync[2] == rx_sync[1])
                rx_clean <= rx_sync[1];
            filt <= {filt[`CSTC_FILTER_TAPS-2:0], rx_clean};
            if (&filt)
                rx_filt <= 1'b1;
            else if (~|filt)
                rx_filt <= 1'b0;
            wake_prev <= wake_line_filter_select ? rx_filt : rx_clean; // see [R16]
        end
    end
    wire wake_line = wake_line_filter_select ? rx_filt : rx_clean; // see [R16]
    wire wake_event = wake_armed & wake_prev & ~wake_line; // see [R08]

    // ----------------------------------------
    // interrupt flags
    // ----------------------------------------
    wire bus_sel = avs_read | avs_write;
    wire wr = avs_write & ~avs_waitrequest;
    wire [7:0] set_low = {ev_invalid_msg, wake_event, error_rise, 1'b0,
        (fill[4:0] >= almost_thr) & ev_fifo_write, ev_rx_overflow, ev_rx_stored,
        ev_tx_done}; // see [R07] see [R09] see [R10] see [R11]
    wire wr_intf = wr & avs_address == `CSTC_ADDR_INTF & avs_byteenable[0];
    wire [7:0] clr_low = wr_intf ? ~avs_writedata[7:0] : 8'h00;

    always @(posedge sys_clk) begin
        if (rst) begin
            flags_low <= 8'h00;
            status_prev <= 8'h00;
            irq <= 1'b0;
        end else begin
            status_prev <= status_high;
            // set beats a same-cycle clear; software writes zero to clear
            flags_low <= ((flags_low & ~clr_low) | set_low) & `CSTC_INTF_LOW_MASK; // see [R07]
            irq <= |(flags_low & inte); // see [R12]
        end
    end

    // ----------------------------------------
    // bit timing
    // ----------------------------------------
    wire tq_tick;
    cstc_quantum #(.PW(6)) u_quantum (
        .sys_clk(sys_clk),
        .rst(rst),
        .quantum_prescaler(quantum_prescaler),
        .tq_tick(tq_tick)
    );

    wire [3:0] ph1_tq = {1'b0, phase_one_length} + 4'h1; // see [R20]
    wire [3:0] prop_tq = {1'b0, propagation_length} + 4'h1; // see [R21]
    wire [3:0] ipt_tq = IPT_TQ[3:0];
    wire [3:0] ph2_tq = phase_two_free_select ? {1'b0, phase_two_length} + 4'h1 :
        ((ph1_tq > ipt_tq) ? ph1_tq : ipt_tq); // see [R17] see [R18]
    wire [3:0] sjw_tq = {2'b00, resync_jump_width} + 4'h1; // see [R14]
    wire [4:0] sp_at = 5'h01 + {1'b0, prop_tq} + {1'b0, ph1_tq};
    wire [4:0] bit_len = sp_at + {1'b0, ph2_tq};
    reg [4:0] tq_pos;
    reg [2:0] samples;

    function maj;
        input [2:0] s;
        maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    always @(posedge sys_clk) begin
        if (rst) begin
            tq_pos <= 5'h00;
            samples <= 3'h7;
            sample_point <= 1'b0;
            sampled_bit <= 1'b1;
            resync_window <= 1'b0;
        end else begin
            sample_point <= 1'b0;
            if (tq_tick) begin
                tq_pos <= (tq_pos + 5'h01 >= bit_len) ? 5'h00 : tq_pos + 5'h01;
                samples <= {samples[1:0], rx_clean};
                if (tq_pos == sp_at) begin
                    sample_point <= 1'b1;
                    sampled_bit <= triple_sample_select ?
                        maj({samples[1:0], rx_clean}) : rx_clean; // see [R19]
                end
                resync_window <= (tq_pos < {1'b0, sjw_tq}); // see [R14]
            end
        end
    end

    // ----------------------------------------
    // avalon register access
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            inte <= 8'h00;
            cfg_a <= 16'h0000;
            cfg_b <= 16'h0000;
            acceptance_filter_on <= `CSTC_FEN_RESET; // see [R22]
            almost_thr <= 5'h18;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            done <= 1'b0;
            err_frame_allowed <= 1'b1;
            ack_allowed <= 1'b1;
        end else begin
            err_frame_allowed <= ~listen_only & ~tx_bus_off; // see [R23]
            ack_allowed <= ~listen_only; // see [R23]
            // one wait cycle lets the read mux settle from registers
            avs_waitrequest <= ~(bus_sel & avs_waitrequest & ~done);
            done <= bus_sel & avs_waitrequest & ~done;
            if (bus_sel & ~avs_waitrequest)
                done <= 1'b0;
            if (avs_read & avs_waitrequest & ~done) begin
                case (avs_address)
                    `CSTC_ADDR_FIFO: avs_readdata <= {16'h0000, 2'b00, fifo_write_index,
                        2'b00, fifo_next_read_index}; // see [R01] see [R02]
                    `CSTC_ADDR_INTF: avs_readdata <= {16'h0000, status_high, flags_low};
                    `CSTC_ADDR_INTE: avs_readdata <= {24'h000000, inte};
                    `CSTC_ADDR_EC: avs_readdata <= {16'h0000, tx_fault_count,
                        rx_fault_count}; // see [R13]
                    `CSTC_ADDR_CFG_A: avs_readdata <= {16'h0000, cfg_a};
                    `CSTC_ADDR_CFG_B: avs_readdata <= {16'h0000, cfg_b};
                    `CSTC_ADDR_FEN: avs_readdata <= {16'h0000, acceptance_filter_on};
                    `CSTC_ADDR_CTRL: avs_readdata <= {27'h0000000, almost_thr};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
            if (wr) begin
                case (avs_address)
                    `CSTC_ADDR_INTE: begin
                        if (avs_byteenable[0])
                            inte <= avs_writedata[7:0] & `CSTC_INTF_LOW_MASK; // see [R12]
                    end
                    `CSTC_ADDR_CFG_A: begin
                        if (avs_byteenable[0])
                            cfg_a <= avs_writedata[15:0] & `CSTC_CFG_A_MASK;
                    end
                    `CSTC_ADDR_CFG_B: begin
                        if (avs_byteenable[0])
                            cfg_b[7:0] <= avs_writedata[7:0];
                        if (avs_byteenable[1])
                            cfg_b[15:8] <= avs_writedata[15:8] & 8'h47;
                    end
                    `CSTC_ADDR_FEN: begin
                        if (avs_byteenable[0])
                            acceptance_filter_on[7:0] <= avs_writedata[7:0]; // see [R22]
                        if (avs_byteenable[1])
                            acceptance_filter_on[15:8] <= avs_writedata[15:8];
                    end
                    `CSTC_ADDR_CTRL: begin
                        if (avs_byteenable[0])
                            almost_thr <= avs_writedata[4:0]; // see [R09]
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // cstc_top

//--- verification/cstc_checker.sv
// checker for bus answers, listen-only, filter enables and sample spacing
`timescale 1ns/1ps
`include "cstc_consts.vh"
module cstc_checker (
    input wire sys_clk,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire listen_only,
    input wire [15:0] acceptance_filter_on,
    input wire sample_point,
    input wire err_frame_allowed,
    input wire ack_allowed
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd(logic [3:0] a);
        avs_read && avs_waitrequest && avs_address == a;
    endsequence
    AST_ONE_WAIT: assert property (s_req |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after request");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address[3]
        |=> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    AST_FIFO_PAD: assert property (s_rd(`CSTC_ADDR_FIFO) |=>
        avs_readdata[31:14] == 18'h00000 && avs_readdata[7:6] == 2'h0)
        else $error("fifo status unused bits not zero");
    AST_CFGA_PAD: assert property (s_rd(`CSTC_ADDR_CFG_A) |=>
        avs_readdata[31:8] == 24'h000000)
        else $error("timing config a unused bits not zero");
    AST_LISTEN: assert property (listen_only |=> !err_frame_allowed && !ack_allowed)
        else $error("error flags or ack allowed in listen-only");
    AST_FEN_RESET: assert property ($fell(rst) |-> acceptance_filter_on == 16'hFFFF)
        else $error("filter enables not all set after reset");
    AST_FEN_HOLD: assert property (!$stable(acceptance_filter_on) |->
        $past(avs_write) && $past(avs_address) == `CSTC_ADDR_FEN)
        else $error("filter enables changed without a write");
    // a bit holds at least four quanta of two clocks
    AST_SAMPLE_GAP: assert property (sample_point |=> !sample_point [*3])
        else $error("sample points too close");
endmodule // cstc_checker

//--- verification/cstc_can_node.sv
// far-side node: pulls the receive line dominant for a commanded span
`timescale 1ns/1ps
module cstc_can_node (
    input wire sys_clk,
    input wire go,
    input wire [7:0] len,
    output reg can_rx
);
    reg [7:0] left = 8'h00;
    initial can_rx = 1'b1;
    // bus idles recessive; dominant only during a burst
    always @(posedge sys_clk) begin
        if (go)
            left <= len;
        else if (left != 8'h00)
            left <= left - 8'h01;
        can_rx <= !(go || left > 8'h01);
    end
endmodule // cstc_can_node

//--- verification/cstc_top_tb.sv
// testbench for status, flags, counters and bit timing registers
`timescale 1ns/1ps
`include "cstc_consts.vh"
module cstc_top_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [9:0] ev = 10'h000;
    logic listen_only = 1'b0;
    logic wake_armed = 1'b0;
    logic go = 1'b0;
    logic [7:0] len = 8'h01;
    logic [31:0] q;
    wire can_rx, wait_s, irq, err_frame_allowed, ack_allowed, sample_point;
    wire sampled_bit, resync_window;
    wire [31:0] rdata;
    wire [15:0] acceptance_filter_on;
    int err_total = 0;
    int n_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    cstc_can_node u_node (.sys_clk(sys_clk), .go(go), .len(len), .can_rx(can_rx));
    cstc_top u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(addr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wait_s), .ev_fifo_write(ev[0]), .ev_fifo_read(ev[1]),
        .fifo_almost_level(5'h00), .ev_invalid_msg(ev[2]), .ev_rx_stored(ev[3]),
        .ev_rx_overflow(ev[4]), .ev_tx_done(ev[5]), .ev_tx_error(ev[6]),
        .ev_tx_success(ev[7]), .ev_rx_error(ev[8]), .ev_rx_success(ev[9]),
        .listen_only(listen_only), .wake_armed(wake_armed), .can_rx(can_rx), .irq(irq),
        .acceptance_filter_on(acceptance_filter_on), .sample_point(sample_point),
        .sampled_bit(sampled_bit), .resync_window(resync_window),
        .err_frame_allowed(err_frame_allowed),
        .ack_allowed(ack_allowed));
    task stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until waitrequest is seen low; no fixed latency assumed
    task bus(input logic [3:0] a, input logic w, input logic [15:0] d);
        int k;
        @(posedge sys_clk);
        addr <= a;
        rd_s <= !w;
        wr_s <= w;
        wd <= {16'h0000, d};
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wait_s !== 1'b0 && k < 40);
        if (k == 40) chk("waitrequest", 32'h0, 32'h1);
        q = rdata;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask
    task rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string nm);
        bus(a, 1'b0, 16'h0000);
        chk(nm, {16'h0000, e}, q & {16'h0000, m});
    endtask
    task pulse(input int i, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ev[i] <= 1'b1;
            @(posedge sys_clk);
            ev[i] <= 1'b0;
        end
    endtask
    task dom(input logic [7:0] n);
        @(posedge sys_clk);
        len <= n;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (40) @(posedge sys_clk);
    endtask
    task t_regs;
        rc(`CSTC_ADDR_FEN, 16'hFFFF, 16'hFFFF, "fen");
        bus(`CSTC_ADDR_CFG_A, 1'b1, 16'hFFFF);
        rc(`CSTC_ADDR_CFG_A, 16'hFFFF, 16'h00FF, "cfg_a");
        bus(`CSTC_ADDR_CFG_B, 1'b1, 16'hFFFF);
        rc(`CSTC_ADDR_CFG_B, 16'hFFFF, 16'h47FF, "cfg_b");
        bus(`CSTC_ADDR_EC, 1'b1, 16'hFFFF);
        rc(`CSTC_ADDR_EC, 16'hFFFF, 16'h0000, "ec");
        bus(`CSTC_ADDR_FEN, 1'b1, 16'h1234);
        rc(`CSTC_ADDR_FEN, 16'hFFFF, 16'h1234, "fen");
        chk("filter", 32'h1234, {16'h0000, acceptance_filter_on});
        bus(`CSTC_ADDR_CFG_A, 1'b1, 16'h0000);
        rc(4'h9, 16'hFFFF, 16'h0000, "unmapped");
    endtask
    task t_fifo;
        pulse(0, 3);
        pulse(1, 1);
        rc(`CSTC_ADDR_FIFO, 16'hFFFF, 16'h0301, "fifo");
        pulse(0, 23);
        rc(`CSTC_ADDR_FIFO, 16'hFFFF, 16'h1A01, "fifo");
        rc(`CSTC_ADDR_INTF, 16'h0008, 16'h0008, "almost full");
        pulse(0, 6);
        rc(`CSTC_ADDR_FIFO, 16'hFFFF, 16'h0001, "fifo wrap");
    endtask
    task t_flags;
        bus(`CSTC_ADDR_INTF, 1'b1, 16'h0000);
        for (int i = 2; i < 6; i++) pulse(i, 1);
        rc(`CSTC_ADDR_INTF, 16'h00FF, 16'h0087, "flags");
        bus(`CSTC_ADDR_INTF, 1'b1, 16'h00FE);
        bus(`CSTC_ADDR_INTF, 1'b1, 16'h00FF);
        rc(`CSTC_ADDR_INTF, 16'h00FF, 16'h0086, "flags");
        chk("irq", 32'h0, {31'h0, irq});
        bus(`CSTC_ADDR_INTE, 1'b1, 16'h0004);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h1, {31'h0, irq});
        bus(`CSTC_ADDR_INTF, 1'b1, 16'h00FB);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        rc(`CSTC_ADDR_INTE, 16'hFFFF, 16'h0004, "inte");
    endtask
    task t_err;
        pulse(6, 12);
        rc(`CSTC_ADDR_INTF, 16'h3F20, 16'h0520, "warn");
        rc(`CSTC_ADDR_EC, 16'hFFFF, 16'h6000, "ec");
        pulse(6, 4);
        pulse(8, 128);
        rc(`CSTC_ADDR_INTF, 16'h3F00, 16'h1F00, "passive");
        pulse(9, 32);
        pulse(7, 1);
        rc(`CSTC_ADDR_INTF, 16'h3F00, 16'h0700, "warn");
        rc(`CSTC_ADDR_EC, 16'hFFFF, 16'h7F60, "ec");
        listen_only <= 1'b1;
        pulse(6, 2);
        rc(`CSTC_ADDR_EC, 16'hFFFF, 16'h7F60, "frozen");
        chk("listen", 32'h0, {30'h0, err_frame_allowed, ack_allowed});
        listen_only <= 1'b0;
        pulse(6, 17);
        rc(`CSTC_ADDR_INTF, 16'h2000, 16'h2000, "bus off");
        rc(`CSTC_ADDR_EC, 16'hFFFF, 16'hFF60, "ec");
    endtask
    task t_wake;
        wake_armed <= 1'b1;
        bus(`CSTC_ADDR_INTF, 1'b1, 16'h0000);
        // a two-clock burst passes the synchroniser but not the line filter
        dom(8'h02);
        rc(`CSTC_ADDR_INTF, 16'h0040, 16'h0000, "glitch");
        dom(8'h14);
        rc(`CSTC_ADDR_INTF, 16'h0040, 16'h0040, "wake");
        bus(`CSTC_ADDR_CFG_B, 1'b1, 16'h07FF);
        bus(`CSTC_ADDR_INTF, 1'b1, 16'h0000);
        dom(8'h02);
        rc(`CSTC_ADDR_INTF, 16'h0040, 16'h0040, "raw wake");
    endtask
    task gap(input logic [15:0] b, input int e, input int ew, input string nm);
        int k;
        int w;
        bus(`CSTC_ADDR_CFG_B, 1'b1, b);
        // only the third spacing is clean; earlier ones may straddle the change
        repeat (3) begin
            k = 0;
            w = 0;
            do begin
                @(posedge sys_clk);
                k++;
                if (resync_window === 1'b1) w++;
            end while (sample_point !== 1'b1 && k < 300);
        end
        chk({nm, " clocks"}, e, k);
        chk({nm, " window"}, ew, w);
    endtask
    // needs 36-clock bits: burst lands on the last of the three samples only
    task vote(input logic [15:0] b, input logic e, input string nm);
        int k;
        bus(`CSTC_ADDR_CFG_B, 1'b1, b);
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (sample_point !== 1'b1 && k < 300);
        repeat (29) @(posedge sys_clk);
        len <= 8'h02;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk(nm, {31'h0, e}, {31'h0, sampled_bit});
    endtask
    task t_timing;
        bus(`CSTC_ADDR_CFG_A, 1'b1, 16'h0081);
        gap(16'h0391, 40, 12, "bit free");
        gap(16'h0001, 24, 12, "bit ipt");
        gap(16'h0011, 36, 12, "bit ph1");
        vote(16'h0011, 1'b0, "single");
        vote(16'h0051, 1'b1, "triple");
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_fifo;
        t_flags;
        t_err;
        t_wake;
        t_timing;
        stop_test;
    end
    // whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        chk("watchdog", 32'h0, 32'h1);
        stop_test;
    end
endmodule // cstc_top_tb
bind cstc_top cstc_checker u_chk (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .listen_only(listen_only),
    .acceptance_filter_on(acceptance_filter_on), .sample_point(sample_point),
    .err_frame_allowed(err_frame_allowed), .ack_allowed(ack_allowed));
